// file: src/aie_pkg.sv
// Purpose: Shared constants and types for the E1 alarm interrupt enable block.
// Assumes: APB with 32-bit data; one register word per offset.
// Notes: Offsets are word indices within the channel window; the byte address is 4 times the offset.
package aie_pkg;
  localparam logic [11:0] AIE_STATUS_OFF = 12'hb02;
  localparam logic [11:0] AIE_ENABLE_OFF = 12'hb03;
  localparam logic [11:0] AIE_ENABLE_IDX = 12'hb03;
  localparam int AIE_ENABLE_BYTE = 4 * 12'hb03;
  localparam int AIE_STATUS_BYTE = 4 * 12'hb02;
  localparam int BIT_LIVE = 7;
  localparam int BIT_MF = 5;
  localparam int BIT_LCV = 3;
  localparam int BIT_FL = 2;
  localparam int BIT_AIS = 1;
  localparam int BIT_RA = 0;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_WMASK = 8'h3f;
  localparam logic [1:0] RA_CONSEC = 2'h2;

  typedef struct packed {
    logic nfas_strobe;
    logic a_bit;
    logic mf_remote_alarm;
    logic line_code_error;
    logic frame_loss;
    logic all_ones;
  } aie_line_t;
endpackage : aie_pkg

// file: src/aie_alarm_irq.sv
// Purpose: Alarm and error interrupt enable, status and live remote alarm state.
// Assumes: Line inputs come from framer logic on pclk; APB byte address = 4 * index.
// Notes: Status clears on read; a new event in the read cycle stays set.
module aie_alarm_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire aie_pkg::aie_line_t line_in,
  output logic remote_alarm_live_state,
  output logic irq
);
  import aie_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  // True when the bus address is the byte address of a register word.
  function automatic logic aie_addr_hit(input logic [15:0] addr, input int byte_off);
    return addr == 16'(byte_off);
  endfunction : aie_addr_hit

  // True when a level differs from its value one cycle earlier.
  function automatic logic aie_level_change(input logic now_val, input logic last_val);
    return now_val != last_val;
  endfunction : aie_level_change

  // Enable readback: bit 7 is the live state and bit 6 always reads zero.
  function automatic logic [31:0] aie_enable_word(input logic live, input logic [7:0] en);
    return {24'h00_0000, live, 1'b0, en[5:0]};
  endfunction : aie_enable_word

  // ==========================================================
  // Storage and decode nets
  // ==========================================================
  logic [7:0] enable_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic live_r;
  logic live_d_r;
  logic [1:0] run_r;
  logic last_a_r;
  aie_line_t prev_r;
  logic setup;
  logic access;
  logic hit_en;
  logic hit_st;
  logic hit_any;
  logic wr_en;
  logic rd_st;
  logic a_repeat;
  logic [7:0] events;
  logic [7:0] req;

  // ==========================================================
  // Bus decode
  // ==========================================================
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign hit_en = aie_addr_hit(paddr, AIE_ENABLE_BYTE);
  assign hit_st = aie_addr_hit(paddr, AIE_STATUS_BYTE);
  assign hit_any = hit_en || hit_st;
  assign wr_en = access && pwrite && hit_en;
  assign rd_st = access && !pwrite && hit_st;

  // ==========================================================
  // Bus answer
  // ==========================================================
  // The slave answers one cycle after setup with no wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !hit_any;
    end
  end

  // Read data is captured at setup and held until the next setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      if (pwrite || !hit_any) begin
        prdata <= 32'h0000_0000;
      end else if (hit_en) begin
        prdata <= aie_enable_word(live_r, enable_r);
      end else begin
        prdata <= {24'h00_0000, status_r};
      end
    end
  end

  // ==========================================================
  // Enable register
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= ENABLE_RESET;
    end else if (wr_en) begin
      enable_r <= pwdata[7:0] & ENABLE_WMASK;
    end
  end

  // ==========================================================
  // Remote alarm from A bit of non-FAS frames
  // ==========================================================
  // A strobe repeats the previous A bit once a run has started after reset.
  assign a_repeat = line_in.nfas_strobe && line_in.a_bit == last_a_r && run_r != 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_a_r <= 1'b0;
    end else if (line_in.nfas_strobe) begin
      last_a_r <= line_in.a_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 2'h0;
    end else if (line_in.nfas_strobe) begin
      if (line_in.a_bit != last_a_r || run_r == 2'h0) begin
        run_r <= 2'h1;
      end else if (run_r < RA_CONSEC) begin
        run_r <= run_r + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_r <= 1'b0;
    end else if (a_repeat && run_r + 2'h1 >= RA_CONSEC) begin
      live_r <= line_in.a_bit;
    end
  end
  assign remote_alarm_live_state = live_r;

  // ==========================================================
  // Event detection: level changes, plus line code error level
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= line_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_d_r <= 1'b0;
    end else begin
      live_d_r <= live_r;
    end
  end

  always_comb begin
    events = 8'h00;
    events[BIT_MF] = aie_level_change(line_in.mf_remote_alarm, prev_r.mf_remote_alarm);
    events[BIT_LCV] = line_in.line_code_error;
    events[BIT_FL] = aie_level_change(line_in.frame_loss, prev_r.frame_loss);
    events[BIT_AIS] = aie_level_change(line_in.all_ones, prev_r.all_ones);
    events[BIT_RA] = aie_level_change(live_r, live_d_r);
  end

  // ==========================================================
  // Sticky status
  // ==========================================================
  // A read clears only the flags it returned, so an event that lands in the setup cycle of the read is kept.
  always_comb begin
    status_nxt = status_r;
    if (rd_st) begin
      status_nxt = status_r & ~prdata[7:0];
    end
    status_nxt = status_nxt | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 8'h00;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ==========================================================
  // Interrupt request
  // ==========================================================
  assign req = status_r & enable_r & ENABLE_WMASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |req;
    end
  end
endmodule : aie_alarm_irq

// file: bench/aie_assertions.sv
// Purpose: Port checks for the alarm block.
// Assumes: APB answers a cycle after setup.
// Notes: en_r mirrors written enables.
module aie_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic remote_alarm_live_state,
  input wire logic irq,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire aie_pkg::aie_line_t line_in
);
  import aie_pkg::*;
  logic [5:0] en_r;
  logic pa_r;
  wire en = pready && paddr == 16'(AIE_ENABLE_BYTE), st = line_in.nfas_strobe, ab = line_in.a_bit;
  wire lv = remote_alarm_live_state;
  always_ff @(posedge pclk or negedge presetn) if (!presetn) pa_r <= 0; else if (st) pa_r <= ab;
  always_ff @(posedge pclk or negedge presetn) if (!presetn) en_r <= 0;
    else if (en && pwrite) en_r <= pwdata[5:0] & 6'h3f;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready) else $error("ready");
  a_enable_read: assert property (en && !pwrite |-> prdata[6:0] == {1'b0, en_r}) else $error("read");
  a_alarm_set: assert property (st && ab && pa_r |=> lv) else $error("set");
  a_alarm_clear: assert property (st && !ab && !pa_r |=> !lv) else $error("clear");
  a_alarm_hold: assert property (!st |=> $stable(lv)) else $error("hold");
  a_lcv_irq: assert property (line_in.line_code_error && en_r[BIT_LCV] |-> ##[1:3] irq) else $error("lcv");
  a_loss_irq: assert property ($changed(line_in.frame_loss) && en_r[BIT_FL] |-> ##[1:3] irq) else $error("fl");
  a_irq_off: assert property ((en_r == 0) [*3] |-> !irq) else $error("off");
  a_mf_irq: assert property ($changed(line_in.mf_remote_alarm) && en_r[BIT_MF] |-> ##[1:3] irq) else $error("mf");
  a_ais_irq: assert property ($changed(line_in.all_ones) && en_r[BIT_AIS] |-> ##[1:3] irq) else $error("ais");
endmodule : aie_sva
bind aie_alarm_irq aie_sva u_aie_sva (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .remote_alarm_live_state, .irq, .paddr, .pwdata, .prdata, .line_in);

// file: bench/aie_line_model.sv
// Purpose: Incoming E1 line source.
// Assumes: Tasks start just after an edge.
// Notes: The A bit is inverted when stale.
module aie_line_model (
  input wire logic pclk,
  output aie_pkg::aie_line_t line_in
);
  import aie_pkg::*;
  initial line_in = '0;
  task automatic frame(input logic a);
    line_in.nfas_strobe <= 1'b1;
    line_in.a_bit <= a;
    @(posedge pclk);
    line_in.nfas_strobe <= 1'b0;
    line_in.a_bit <= ~a;
    repeat (4) @(posedge pclk);
  endtask : frame
  task automatic kick(input int b);
    line_in[b] <= ~line_in[b];
    @(posedge pclk);
    if (b == 2) line_in[b] <= 1'b0;
  endtask : kick
endmodule : aie_line_model

// file: bench/tb_aie_alarm_irq.sv
// Purpose: Bench for the alarm block.
// Assumes: 50 MHz pclk.
// Notes: Reads compare whole words.
module tb_aie_alarm_irq;
  timeunit 1ns;
  timeprecision 1ns;
  import aie_pkg::*;
  localparam logic [15:0] EN = 16'(AIE_ENABLE_BYTE), ST = 16'(AIE_STATUS_BYTE);
  localparam int SRC_BIT [4] = '{BIT_AIS, BIT_FL, BIT_LCV, BIT_MF};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, live, irq;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  aie_line_t line_in;
  int err_count = 0, n_compared = 0, cyc = 0;
  aie_alarm_irq u_aie_alarm_irq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .line_in, .remote_alarm_live_state(live), .irq);
  aie_line_model u_aie_line_model (.pclk, .line_in);
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) if (++cyc == 4000) begin err_count++; test_done(); end
  task automatic check(input string s, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin err_count++; $display("FAIL %s exp %h seen %h", s, exp, seen); end
  endtask : check
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, exp);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) check("prdata", prdata, exp);
    check("pslverr", pslverr, 32'(a != EN && a != ST));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic test_done();
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, EN, 0, 0);
    check("live", live, 0);
    check("irq", irq, 0);
    apb(0, 16'h0004, 0, 0);
    apb(1, EN, 32'hef, 0);
    apb(0, EN, 0, 32'h2f);
    for (int i = 0; i < 4; i++) begin
      u_aie_line_model.frame(i < 2);
      if (i > 0) begin
        apb(0, EN, 0, i > 2 ? 32'h2f : 32'haf);
        check("live", live, 32'(i < 3));
      end
    end
    check("irq", irq, 1);
    apb(0, ST, 0, 32'h01);
    apb(0, ST, 0, 0);
    for (int i = 0; i < 2; i++) begin
      apb(1, EN, i ? 32'h0 : 32'h2f, 0);
      for (int b = 0; b < 4; b++) begin
        @(posedge pclk);
        check("irq idle", irq, 0);
        u_aie_line_model.kick(b);
        repeat (3) @(posedge pclk);
        check("irq", irq, 32'(1 - i));
        apb(0, ST, 0, 32'h1 << SRC_BIT[b]);
      end
    end
    test_done();
  end
endmodule : tb_aie_alarm_irq
